// File: testbench/field_reader.sv
`timescale 1ns/1ps
// reader side: makes the field clock and measures how long the load level stays put
module field_reader (
    output logic        field_clk,
    input  wire logic   modulation,
    input  wire logic   clr,
    output logic [15:0] min_run,
    output logic [15:0] max_run
);
    logic [15:0] run;
    logic        last;
    logic        seen;

    // the field runs free while the tag sits in it, phase unrelated to the core clock
    initial begin
        field_clk = 1'b0;
        #1.3;
        forever #7.5 field_clk = ~field_clk;
    end

    // falling edge sampling keeps clear of the tag's own update; first partial run dropped
    always @(negedge field_clk) begin
        if (clr) begin
            seen    = 1'b0;
            min_run = 16'hFFFF;
            max_run = 16'h0000;
        end else if (modulation === last) begin
            run = run + 16'h0001;
        end else begin
            if (seen && run < min_run) min_run = run;
            if (seen && run > max_run) max_run = run;
            seen = 1'b1;
            run  = 16'h0001;
        end
        last = modulation;
    end
endmodule : field_reader

// File: testbench/transponder_chk.sv
`timescale 1ns/1ps
// watches the write port and the block sequencer of the read-out path
module transponder_chk (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        wr_req,
    input wire logic [2:0]  wr_block,
    input wire logic [32:0] wr_data,
    input wire logic        wr_done,
    input wire logic        wr_refused,
    input wire logic        running,
    input wire logic [2:0]  tx_block
);
    logic [7:0] lock_ff;
    logic [7:0] nxt_lock;
    logic [8:0] age_ff;
    logic [8:0] nxt_age;

    // shadow of the lock bits, so refusals can be predicted; age saturates
    always_comb begin
        nxt_lock = lock_ff;
        nxt_age  = (age_ff == 9'h1FF) ? age_ff : age_ff + 9'h001;
        if (wr_req && !lock_ff[wr_block]) nxt_lock[wr_block] = wr_data[0];
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lock_ff <= 8'h00;
            age_ff  <= 9'h000;
        end else begin
            lock_ff <= nxt_lock;
            age_ff  <= nxt_age;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_accept; wr_req && !lock_ff[wr_block] |=> wr_done && !wr_refused; endproperty
    a_accept: assert property (p_accept) else $error("write not stored");
    property p_refuse; wr_req && lock_ff[wr_block] |=> wr_refused && !wr_done; endproperty
    a_refuse: assert property (p_refuse) else $error("locked block not refused");
    property p_no_answer; !wr_req |=> !wr_done && !wr_refused; endproperty
    a_no_answer: assert property (p_no_answer) else $error("answer without request");
    property p_por_hold; age_ff < 9'h0BE |-> !running; endproperty
    a_por_hold: assert property (p_por_hold) else $error("running before delay");
    property p_por_end; age_ff > 9'h0D2 |-> running; endproperty
    a_por_end: assert property (p_por_end) else $error("not running after delay");
    property p_first_blk; $rose(running) |-> ##[0:4] tx_block == 3'h0; endproperty
    a_first_blk: assert property (p_first_blk) else $error("first block not block 0");
    property p_blk_step; running && $past(running) && $changed(tx_block)
        |-> tx_block == $past(tx_block) + 3'h1 || tx_block <= 3'h1; endproperty
    a_blk_step: assert property (p_blk_step) else $error("block order broken");
    property p_blk_hold; $changed(tx_block) |=> $stable(tx_block) [*8]; endproperty
    a_blk_hold: assert property (p_blk_hold) else $error("block too short");
endmodule : transponder_chk

bind transponder_readout_modulator transponder_chk u_transponder_chk (
    .clock(clock), .rstn(rstn), .wr_req(wr_req), .wr_block(wr_block), .wr_data(wr_data),
    .wr_done(wr_done), .wr_refused(wr_refused), .running(running), .tx_block(tx_block)
);

// File: testbench/transponder_readout_modulator_tb.sv
`timescale 1ns/1ps
module transponder_readout_modulator_tb;
    localparam logic [32:0] ALT = 33'h155555554;
    localparam logic [32:0] ONE = 33'h1FFFFFFFE;
    logic        clock    = 1'b0;
    logic        rstn     = 1'b0;
    logic        wr_req   = 1'b0;
    logic [2:0]  wr_block = 3'h0;
    logic [32:0] wr_data  = 33'h000000000;
    logic        clr      = 1'b0;
    logic        field_clk;
    logic        wr_done;
    logic        wr_refused;
    logic        running;
    logic [2:0]  tx_block;
    logic        modulation;
    logic [15:0] min_run;
    logic [15:0] max_run;
    int          n_errors    = 0;
    int          check_count = 0;
    int          cycles      = 0;
    int          last_p      = 8;

    initial forever #2.5 clock = ~clock;

    transponder_readout_modulator u_transponder_readout_modulator (
        .clock(clock), .rstn(rstn), .field_clk(field_clk), .wr_req(wr_req), .wr_block(wr_block),
        .wr_data(wr_data), .wr_done(wr_done), .wr_refused(wr_refused), .running(running),
        .tx_block(tx_block), .modulation(modulation)
    );
    field_reader u_field_reader (
        .field_clk(field_clk), .modulation(modulation), .clr(clr), .min_run(min_run), .max_run(max_run)
    );

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // a hang is cut short well past the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic wr(input logic [2:0] blk, input logic [32:0] d, input logic refuse);
        cyc(1);
        wr_req   = 1'b1;
        wr_block = blk;
        wr_data  = d;
        cyc(1);
        wr_req = 1'b0;
        check(16'(wr_done), 16'(!refuse));
        check(16'(wr_refused), 16'(refuse));
    endtask : wr

    // mode word: each field has its most significant bit at the lowest bit number
    function automatic logic [32:0] cfg(input logic [2:0] rt, input logic [1:0] s1, input logic [2:0] s2,
                                        input logic [1:0] cf, input logic [2:0] mb);
        logic [32:0] w;
        w = 33'h000000000;
        for (int i = 0; i < 3; i++) begin
            w[transponder_pkg::RATE_POS + i]   = rt[2 - i];
            w[transponder_pkg::ENC2_POS + i]   = s2[2 - i];
            w[transponder_pkg::MAXBLK_POS + i] = mb[2 - i];
        end
        for (int i = 0; i < 2; i++) begin
            w[transponder_pkg::ENC1_POS + i] = s1[1 - i];
            w[transponder_pkg::CARR_POS + i] = cf[1 - i];
        end
        return w;
    endfunction : cfg

    task automatic t_por();
        cyc(150);
        check(16'(running), 16'h0000);
        for (int i = 0; i < 100 && running !== 1'b1; i++) cyc(1);
        check(16'(running), 16'h0001);
        cyc(2);
        check(16'(tx_block), 16'h0000);
    endtask : t_por

    task automatic t_writes();
        wr(3'h6, 33'h02468ACF1, 1'b0);
        wr(3'h6, 33'h000000000, 1'b1);
        wr(3'h6, ONE, 1'b1);
        wr(3'h7, 33'h000000001, 1'b0);
        wr(3'h5, 33'h13579BDE0, 1'b0);
        wr(3'h5, 33'h000000000, 1'b0);
    endtask : t_writes

    task automatic blk_next(input logic [2:0] exp);
        logic [2:0] cur;
        cur = tx_block;
        for (int i = 0; i < 3000 && tx_block === cur; i++) cyc(1);
        check(16'(tx_block), 16'(exp));
    endtask : blk_next

    task automatic t_order();
        wr(3'h0, cfg(3'h0, 2'h0, 3'h0, 2'h0, 3'h3), 1'b0);
        for (int i = 0; i < 9000 && tx_block !== 3'h3; i++) cyc(1);
        blk_next(3'h1);
        blk_next(3'h2);
        blk_next(3'h3);
        blk_next(3'h1);
        wr(3'h0, cfg(3'h0, 2'h0, 3'h0, 2'h0, 3'h0), 1'b0);
        for (int i = 0; i < 9000 && tx_block !== 3'h0; i++) cyc(1);
        cyc(2000);
        check(16'(tx_block), 16'h0000);
    endtask : t_order

    // block 1 alone is sent; up to about 50 cells of the old mode, at the old period, drain first
    task automatic t_mode(input logic [2:0] rt, input logic [1:0] s1, input logic [2:0] s2,
                          input logic [1:0] cf, input logic [32:0] d, input int p, input int mn, input int mx);
        wr(3'h1, d, 1'b0);
        wr(3'h0, cfg(rt, s1, s2, cf, 3'h1), 1'b0);
        cyc(last_p * 165 + p * 9);
        last_p = p;
        clr = 1'b1;
        cyc(8);
        clr = 1'b0;
        cyc(p * 54);
        check(min_run, 16'(mn));
        check(max_run, 16'(mx));
    endtask : t_mode

    // run lengths in field cycles; no split phase stage behind a split first stage
    task automatic t_encoders();
        t_mode(3'h0, 2'h0, 3'h0, 2'h0, ALT, 8, 8, 8);
        t_mode(3'h2, 2'h0, 3'h0, 2'h0, ALT, 32, 32, 32);
        t_mode(3'h1, 2'h1, 3'h0, 2'h0, ONE, 16, 8, 8);
        t_mode(3'h1, 2'h1, 3'h0, 2'h0, ALT, 16, 16, 16);
        t_mode(3'h1, 2'h2, 3'h0, 2'h0, ONE, 16, 8, 8);
        t_mode(3'h1, 2'h2, 3'h0, 2'h0, 33'h000000000, 16, 16, 16);
        t_mode(3'h1, 2'h0, 3'h4, 2'h0, 33'h000000000, 16, 4, 4);
        t_mode(3'h3, 2'h0, 3'h4, 2'h0, ONE, 40, 2, 3);
        t_mode(3'h3, 2'h0, 3'h5, 2'h0, ONE, 40, 5, 5);
        t_mode(3'h1, 2'h0, 3'h6, 2'h0, ONE, 16, 4, 4);
        t_mode(3'h3, 2'h0, 3'h7, 2'h0, 33'h000000000, 40, 5, 5);
        t_mode(3'h0, 2'h0, 3'h1, 2'h0, 33'h000000000, 8, 1, 1);
        t_mode(3'h1, 2'h0, 3'h2, 2'h1, ONE, 16, 2, 4);
        t_mode(3'h1, 2'h0, 3'h3, 2'h2, 33'h000000000, 16, 4, 4);
    endtask : t_encoders

    // a set lock bit with zero data must leave the load level untouched
    task automatic t_lock_out();
        t_mode(3'h0, 2'h0, 3'h0, 2'h0, 33'h000000001, 8, 65535, 0);
        wr(3'h1, ONE, 1'b1);
    endtask : t_lock_out

    initial begin
        cyc(3);
        rstn = 1'b1;
        t_por();
        t_writes();
        t_order();
        t_encoders();
        t_lock_out();
        stop_test();
    end
endmodule : transponder_readout_modulator_tb

// File: verilog/transponder_pkg.sv
package transponder_pkg;

    // memory organisation
    localparam int BLOCKS        = 8;
    localparam int BLOCK_BITS    = 33;
    localparam int LOCK_BIT      = 0;
    localparam int DATA_FIRST    = 1;
    localparam int DATA_LAST     = 32;
    localparam int CONFIG_BLOCK  = 0;
    localparam int FIRST_USER    = 1;

    // configuration block field positions, most significant bit at the lowest bit number
    localparam int RATE_POS      = 12;
    localparam int ENC1_POS      = 16;
    localparam int ENC2_POS      = 18;
    localparam int CARR_POS      = 21;
    localparam int MAXBLK_POS    = 25;

    // first stage encodings
    localparam logic [1:0] ENC1_DIRECT = 2'h0;
    localparam logic [1:0] ENC1_MANCH  = 2'h1;
    localparam logic [1:0] ENC1_BIPH   = 2'h2;

    // second stage encodings
    localparam logic [2:0] ENC2_DIRECT = 3'h0;
    localparam logic [2:0] ENC2_PSK1   = 3'h1;
    localparam logic [2:0] ENC2_PSK2   = 3'h2;
    localparam logic [2:0] ENC2_PSK3   = 3'h3;
    localparam logic [2:0] ENC2_FSK1   = 3'h4;
    localparam logic [2:0] ENC2_FSK2   = 3'h5;
    localparam logic [2:0] ENC2_FSK1A  = 3'h6;
    localparam logic [2:0] ENC2_FSK2A  = 3'h7;

    // phase carrier divider codes: fc/2, fc/4, fc/8
    localparam logic [1:0] CARR_DIV2 = 2'h0;
    localparam logic [1:0] CARR_DIV4 = 2'h1;
    localparam logic [1:0] CARR_DIV8 = 2'h2;

    // tone periods in field cycles
    localparam logic [3:0] FSK_LOW    = 4'h8;
    localparam logic [3:0] FSK_HIGH5  = 4'h5;
    localparam logic [3:0] FSK_HIGH10 = 4'hA;

    // power-on delay
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int POR_DELAY_NS    = 1000;
    localparam int POR_CYCLES      = (POR_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // stream word: {carrier divider, stage 2, stage 1, bit rate, data}
    localparam int WORD_W     = 11;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        SEQ_POR  = 2'b00,
        SEQ_LOAD = 2'b01,
        SEQ_SEND = 2'b10
    } seq_state_e;

    function automatic logic [2:0] field3(input logic [32:0] w, input int p);
        field3 = {w[p], w[p+1], w[p+2]};
    endfunction : field3

    function automatic logic [1:0] field2(input logic [32:0] w, input int p);
        field2 = {w[p], w[p+1]};
    endfunction : field2

    // bit cell length in field cycles
    function automatic logic [7:0] bit_period(input logic [2:0] rt);
        case (rt)
            3'h0:    bit_period = 8'h08;
            3'h1:    bit_period = 8'h10;
            3'h2:    bit_period = 8'h20;
            3'h3:    bit_period = 8'h28;
            3'h4:    bit_period = 8'h32;
            3'h5:    bit_period = 8'h40;
            3'h6:    bit_period = 8'h64;
            default: bit_period = 8'h80;
        endcase
    endfunction : bit_period

endpackage : transponder_pkg

// File: verilog/transponder_readout_modulator.sv
`timescale 1ns/1ps

// synchronous first-in first-out buffer, one clock
module stream_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_ff [0:DEPTH-1];
    logic [AW:0]      wptr_ff;
    logic [AW:0]      rptr_ff;
    logic [AW:0]      nxt_wptr;
    logic [AW:0]      nxt_rptr;
    logic             push;
    logic             pop;

    // full when pointers differ only in the wrap bit
    always_comb begin
        in_ready  = (wptr_ff[AW] == rptr_ff[AW]) || (wptr_ff[AW-1:0] != rptr_ff[AW-1:0]);
        out_valid = (wptr_ff != rptr_ff);
        out_data  = store_ff[rptr_ff[AW-1:0]];
        push      = in_valid & in_ready;
        pop       = out_valid & out_ready;
        nxt_wptr  = push ? wptr_ff + 1'b1 : wptr_ff;
        nxt_rptr  = pop ? rptr_ff + 1'b1 : rptr_ff;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
        end else begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
        end
    end

    // storage has no reset; only written slots are ever read
    always_ff @(posedge clock) begin
        if (push) begin
            store_ff[wptr_ff[AW-1:0]] <= in_data;
        end
    end
endmodule : stream_fifo

// Overview of operation
// - mode register reloaded from block 0 at start of every transmitted block
// - after power-on, mode register loaded from block 0 before transmission starts
// - delayed start after reset; logic held in start state until delay expires
// - two cascaded encoder stages, each chosen separately from mode data
// - phase mode inverts carrier on change, one, or rising edge; fc/2, fc/4, fc/8
// - frequency mode uses tones rf/8 with rf/5, or rf/8 with rf/10
// - Manchester: high bit is rising mid-cell edge, low bit falling
// - biphase toggles at each bit boundary, plus mid-bit for a high bit
// - bit periods 8, 16, 32, 40, 50, 64, 100 or 128 field cycles
// - memory is 8 blocks of 33 bits addressed by block number
// - a block write programs all 33 bits at once, lock bit included
// - block 0 holds configuration and is normally not transmitted
// - blocks 1 to 6 user storage; block 7 password or user storage
// - bit 0 locks its block; any write to a locked block is refused
// - read-out from bit 1 of block 1 to bit 32 of last block; no lock bit
// - last-block value 0 to 7; value 0 sends only block 0
module transponder_readout_modulator (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        field_clk,
    input  wire logic        wr_req,
    input  wire logic [2:0]  wr_block,
    input  wire logic [32:0] wr_data,
    output logic             wr_done,
    output logic             wr_refused,
    output logic             running,
    output logic [2:0]       tx_block,
    output logic             modulation
);
    localparam int W = transponder_pkg::WORD_W;

    // ---------------- core domain: memory and write port ----------------
    logic [32:0] mem_ff [0:transponder_pkg::BLOCKS-1];
    logic        wr_done_ff;
    logic        wr_refused_ff;
    logic        nxt_wr_done;
    logic        nxt_wr_refused;

    // whole-block write, refused when the stored lock bit is set
    always_comb begin
        nxt_wr_done    = wr_req & ~mem_ff[wr_block][transponder_pkg::LOCK_BIT];
        nxt_wr_refused = wr_req & mem_ff[wr_block][transponder_pkg::LOCK_BIT];
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < transponder_pkg::BLOCKS; i++) begin
                mem_ff[i] <= '0;
            end
            wr_done_ff    <= 1'b0;
            wr_refused_ff <= 1'b0;
        end else begin
            if (nxt_wr_done) begin
                mem_ff[wr_block] <= wr_data;
            end
            wr_done_ff    <= nxt_wr_done;
            wr_refused_ff <= nxt_wr_refused;
        end
    end

    // ---------------- core domain: read-out sequencer ----------------
    transponder_pkg::seq_state_e state_ff, nxt_state;
    logic [7:0]  por_cnt_ff, nxt_por_cnt;
    logic [2:0]  blk_ff, nxt_blk;
    logic [5:0]  bit_ff, nxt_bit;
    logic [2:0]  rate_ff, nxt_rate;
    logic [1:0]  enc1_ff, nxt_enc1;
    logic [2:0]  enc2_ff, nxt_enc2;
    logic [1:0]  carr_ff, nxt_carr;
    logic [2:0]  maxblk_ff, nxt_maxblk;
    logic        running_ff, nxt_running;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic [W-1:0] fifo_in_data;
    logic [32:0] cfg;

    always_comb begin
        cfg           = mem_ff[transponder_pkg::CONFIG_BLOCK];
        nxt_state     = state_ff;
        nxt_por_cnt   = por_cnt_ff;
        nxt_blk       = blk_ff;
        nxt_bit       = bit_ff;
        nxt_rate      = rate_ff;
        nxt_enc1      = enc1_ff;
        nxt_enc2      = enc2_ff;
        nxt_carr      = carr_ff;
        nxt_maxblk    = maxblk_ff;
        fifo_in_valid = 1'b0;
        fifo_in_data  = {carr_ff, enc2_ff, enc1_ff, rate_ff, mem_ff[blk_ff][bit_ff]};
        case (state_ff)
            transponder_pkg::SEQ_POR: begin
                // nothing moves until the power-on delay has run out
                if (por_cnt_ff == 8'(transponder_pkg::POR_CYCLES - 1)) begin
                    nxt_state = transponder_pkg::SEQ_LOAD;
                end else begin
                    nxt_por_cnt = por_cnt_ff + 8'h01;
                end
            end
            transponder_pkg::SEQ_LOAD: begin
                // refresh mode data from the configuration block at each block start
                nxt_rate   = transponder_pkg::field3(cfg, transponder_pkg::RATE_POS);
                nxt_enc1   = transponder_pkg::field2(cfg, transponder_pkg::ENC1_POS);
                nxt_enc2   = transponder_pkg::field3(cfg, transponder_pkg::ENC2_POS);
                nxt_carr   = transponder_pkg::field2(cfg, transponder_pkg::CARR_POS);
                nxt_maxblk = transponder_pkg::field3(cfg, transponder_pkg::MAXBLK_POS);
                if (nxt_maxblk == 3'h0) begin
                    nxt_blk = 3'(transponder_pkg::CONFIG_BLOCK);
                end else if (blk_ff == 3'h0 || blk_ff >= nxt_maxblk) begin
                    nxt_blk = 3'(transponder_pkg::FIRST_USER);
                end else begin
                    nxt_blk = blk_ff + 3'h1;
                end
                nxt_bit   = 6'(transponder_pkg::DATA_FIRST);
                nxt_state = transponder_pkg::SEQ_SEND;
            end
            transponder_pkg::SEQ_SEND: begin
                // a full buffer stalls the sequencer on the current bit
                fifo_in_valid = 1'b1;
                if (fifo_in_ready) begin
                    if (bit_ff == 6'(transponder_pkg::DATA_LAST)) begin
                        nxt_state = transponder_pkg::SEQ_LOAD;
                    end else begin
                        nxt_bit = bit_ff + 6'h01;
                    end
                end
            end
            default: nxt_state = transponder_pkg::SEQ_POR;
        endcase
        nxt_running = (nxt_state != transponder_pkg::SEQ_POR);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff   <= transponder_pkg::SEQ_POR;
            por_cnt_ff <= 8'h00;
            blk_ff     <= 3'h0;
            bit_ff     <= 6'h01;
            rate_ff    <= 3'h0;
            enc1_ff    <= 2'h0;
            enc2_ff    <= 3'h0;
            carr_ff    <= 2'h0;
            maxblk_ff  <= 3'h0;
            running_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            por_cnt_ff <= nxt_por_cnt;
            blk_ff     <= nxt_blk;
            bit_ff     <= nxt_bit;
            rate_ff    <= nxt_rate;
            enc1_ff    <= nxt_enc1;
            enc2_ff    <= nxt_enc2;
            carr_ff    <= nxt_carr;
            maxblk_ff  <= nxt_maxblk;
            running_ff <= nxt_running;
        end
    end

    logic         fifo_out_valid;
    logic         fifo_out_ready;
    logic [W-1:0] fifo_out_data;

    stream_fifo #(
        .WIDTH (W),
        .DEPTH (transponder_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rstn      (rstn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ---------------- core domain: handshake toward the field clock ----------------
    logic         req_meta_ff, req_sync_ff, req_seen_ff;
    logic         pend_ff, nxt_pend;
    logic         ack_tgl_ff, nxt_ack_tgl;
    logic [W-1:0] xfer_ff, nxt_xfer;
    logic         req_tgl_ff;

    // the word lands in xfer_ff on the same edge that toggles the acknowledge and holds until the next request
    always_comb begin
        fifo_out_ready = pend_ff & fifo_out_valid;
        nxt_pend       = (pend_ff & ~fifo_out_ready) | (req_sync_ff ^ req_seen_ff);
        nxt_ack_tgl    = ack_tgl_ff ^ fifo_out_ready;
        nxt_xfer       = fifo_out_ready ? fifo_out_data : xfer_ff;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            req_meta_ff <= 1'b0;
            req_sync_ff <= 1'b0;
            req_seen_ff <= 1'b0;
            pend_ff     <= 1'b0;
            ack_tgl_ff  <= 1'b0;
            xfer_ff     <= '0;
        end else begin
            req_meta_ff <= req_tgl_ff;
            req_sync_ff <= req_meta_ff;
            req_seen_ff <= req_sync_ff;
            pend_ff     <= nxt_pend;
            ack_tgl_ff  <= nxt_ack_tgl;
            xfer_ff     <= nxt_xfer;
        end
    end

    // ---------------- field domain: bit cells and encoders ----------------
    logic         ack_meta_ff, ack_sync_ff, ack_seen_ff;
    logic [W-1:0] next_word_ff, nxt_next_word;
    logic         next_ok_ff, nxt_next_ok;
    logic         wait_ff, nxt_wait;
    logic         nxt_req_tgl;
    logic [W-1:0] cur_ff, nxt_cur;
    logic [7:0]   cnt_ff, nxt_cnt;
    logic         bip_ff, nxt_bip;
    logic         s1_prev_ff, nxt_s1_prev;
    logic         phase_ff, nxt_phase;
    logic [2:0]   pc_ff, nxt_pc;
    logic [3:0]   fsk_cnt_ff, nxt_fsk_cnt;
    logic         mod_ff, nxt_mod;
    logic [7:0]   period;
    logic         boundary;
    logic         d;
    logic         half;
    logic         s1;
    logic         carrier;
    logic [3:0]   fsk_per;

    always_comb begin
        period        = transponder_pkg::bit_period(cur_ff[3:1]);
        boundary      = (cnt_ff == period - 8'h01);
        d             = cur_ff[0];
        half          = (cnt_ff >= (period >> 1));
        nxt_next_word = next_word_ff;
        nxt_next_ok   = next_ok_ff;
        nxt_wait      = wait_ff;
        nxt_req_tgl   = req_tgl_ff;
        nxt_cur       = cur_ff;
        nxt_bip       = bip_ff;
        nxt_cnt       = cnt_ff + 8'h01;
        if (boundary) begin
            // an empty stream sends zero cells under the last mode rather than stopping
            nxt_cnt     = 8'h00;
            nxt_cur     = next_ok_ff ? next_word_ff : {cur_ff[W-1:1], 1'b0};
            nxt_next_ok = 1'b0;
            nxt_bip     = ~(bip_ff ^ d);
            if (!wait_ff) begin
                nxt_req_tgl = ~req_tgl_ff;
                nxt_wait    = 1'b1;
            end
        end
        // taken after the cell edge, so a word landing on the edge costs one cell instead of being lost
        if (ack_sync_ff ^ ack_seen_ff) begin
            nxt_next_word = xfer_ff;
            nxt_next_ok   = 1'b1;
            nxt_wait      = 1'b0;
        end
        // first stage; a biphase cell starts at the inverse of the previous cell's final level
        case (cur_ff[5:4])
            transponder_pkg::ENC1_MANCH: s1 = half ? d : ~d;
            transponder_pkg::ENC1_BIPH:  s1 = bip_ff ^ (half & d);
            default:                    s1 = d;
        endcase
        // phase decision is taken on the first cycle of each cell
        nxt_phase   = phase_ff;
        nxt_s1_prev = s1_prev_ff;
        if (cnt_ff == 8'h00) begin
            nxt_s1_prev = s1;
            case (cur_ff[8:6])
                transponder_pkg::ENC2_PSK1: nxt_phase = phase_ff ^ (s1 ^ s1_prev_ff);
                transponder_pkg::ENC2_PSK2: nxt_phase = phase_ff ^ s1;
                transponder_pkg::ENC2_PSK3: nxt_phase = phase_ff ^ (s1 & ~s1_prev_ff);
                default:                   nxt_phase = phase_ff;
            endcase
        end
        // free-running carrier; keeps phase with the cell only when it divides the period
        nxt_pc = pc_ff + 3'h1;
        case (cur_ff[10:9])
            transponder_pkg::CARR_DIV4: carrier = pc_ff[1];
            transponder_pkg::CARR_DIV8: carrier = pc_ff[2];
            default:                     carrier = pc_ff[0];
        endcase
        // tone selection; the a-variants swap the tones
        if (s1 ^ cur_ff[7]) begin
            fsk_per = cur_ff[6] ? transponder_pkg::FSK_HIGH10 : transponder_pkg::FSK_HIGH5;
        end else begin
            fsk_per = transponder_pkg::FSK_LOW;
        end
        nxt_fsk_cnt = (fsk_cnt_ff >= fsk_per - 4'h1) ? 4'h0 : fsk_cnt_ff + 4'h1;
        // second stage
        case (cur_ff[8:6])
            transponder_pkg::ENC2_DIRECT: nxt_mod = s1;
            transponder_pkg::ENC2_PSK1,
            transponder_pkg::ENC2_PSK2,
            transponder_pkg::ENC2_PSK3:   nxt_mod = carrier ^ nxt_phase;
            default:                     nxt_mod = (fsk_cnt_ff < (fsk_per >> 1));
        endcase
    end

    always_ff @(posedge field_clk or negedge rstn) begin
        if (!rstn) begin
            ack_meta_ff  <= 1'b0;
            ack_sync_ff  <= 1'b0;
            ack_seen_ff  <= 1'b0;
            next_word_ff <= '0;
            next_ok_ff   <= 1'b0;
            wait_ff      <= 1'b0;
            req_tgl_ff   <= 1'b0;
            cur_ff       <= '0;
            cnt_ff       <= 8'h00;
            bip_ff       <= 1'b0;
            s1_prev_ff   <= 1'b0;
            phase_ff     <= 1'b0;
            pc_ff        <= 3'h0;
            fsk_cnt_ff   <= 4'h0;
            mod_ff       <= 1'b0;
        end else begin
            ack_meta_ff  <= ack_tgl_ff;
            ack_sync_ff  <= ack_meta_ff;
            ack_seen_ff  <= ack_sync_ff;
            next_word_ff <= nxt_next_word;
            next_ok_ff   <= nxt_next_ok;
            wait_ff      <= nxt_wait;
            req_tgl_ff   <= nxt_req_tgl;
            cur_ff       <= nxt_cur;
            cnt_ff       <= nxt_cnt;
            bip_ff       <= nxt_bip;
            s1_prev_ff   <= nxt_s1_prev;
            phase_ff     <= nxt_phase;
            pc_ff        <= nxt_pc;
            fsk_cnt_ff   <= nxt_fsk_cnt;
            mod_ff       <= nxt_mod;
        end
    end

    assign wr_done    = wr_done_ff;
    assign wr_refused = wr_refused_ff;
    assign running    = running_ff;
    assign tx_block   = blk_ff;
    assign modulation = mod_ff;
endmodule : transponder_readout_modulator
